// file: dec_params.svh
`ifndef DEC_PARAMS_SVH
`define DEC_PARAMS_SVH

// Register byte addresses (no printed offsets; chosen locally)
`define DEC_ADDR_STATUS    8'h00
`define DEC_ADDR_ADDRESS   8'h04
`define DEC_ADDR_IRQ_STAT  8'h08
`define DEC_ADDR_IRQ_MASK  8'h0C

// Field positions
`define DEC_DIR_BIT        31
`define DEC_CH_MSB         2
`define DEC_CH_LSB         0
`define DEC_IRQ_ERR_BIT    0

// Reset values
`define DEC_STATUS_RESET   32'h00000000
`define DEC_ADDRESS_RESET  32'h00000000
`define DEC_IRQ_RESET      1'b0

// AXI responses
`define DEC_RESP_OKAY      2'b00
`define DEC_RESP_SLVERR    2'b10

`endif

// file: dec_pkg.sv
package dec_pkg;
   typedef struct packed {
      logic        strobe;
      logic        was_read;
      logic [2:0]  channel;
      logic [31:0] address;
   } dec_error_t;

   typedef struct packed {
      logic        was_read;
      logic [2:0]  channel;
      logic [31:0] address;
   } dec_capture_t;
endpackage : dec_pkg

// file: dec_capture.sv
`timescale 1ns/1ps
`include "dec_params.svh"

module dec_capture
   import dec_pkg::*;
(
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // Error event from the engine
   input  wire dec_error_t   err_in,
   // Captured record
   output dec_capture_t      captured
);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         captured <= '0; // [R05]
      end else if (err_in.strobe) begin
         captured.was_read <= err_in.was_read; // [R01]
         captured.channel  <= err_in.channel;  // [R02]
         captured.address  <= err_in.address;  // [R03]
      end
   end

endmodule : dec_capture

// file: dec_error_capture.sv
//
// Overview of operation
// [R01] On a bus error the top status bit records 1 for a failed read and 0 for a failed write.
// [R02] On a bus error the low three status bits record the most recently active channel number.
// [R03] On a bus error the address register records the full 32-bit address of the failing access.
// [R04] Status bits 30 to 3 always read zero and ignore writes.
// [R05] Both capture registers reset to zero, are read-only, and change only on a new error.
//
`timescale 1ns/1ps
`include "dec_params.svh"

module dec_error_capture
   import dec_pkg::*;
(
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // Error report from the DMA engine
   input  wire logic         err_strobe,
   input  wire logic         err_was_read,
   input  wire logic [2:0]   err_channel,
   input  wire logic [31:0]  err_address,
   // AXI4-Lite write address
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire logic [7:0]   s_axi_awaddr,
   input  wire logic [2:0]   s_axi_awprot,
   // AXI4-Lite write data
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   // AXI4-Lite write response
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   output logic [1:0]        s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   input  wire logic [7:0]   s_axi_araddr,
   input  wire logic [2:0]   s_axi_arprot,
   // AXI4-Lite read data
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   // Interrupt
   output logic              irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Capture registers

   dec_error_t   err_in;
   dec_capture_t captured;

   assign err_in = '{strobe: err_strobe, was_read: err_was_read,
                     channel: err_channel, address: err_address};

   dec_capture u_capture (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .err_in   (err_in),
      .captured (captured)
   );

   wire logic [31:0] status_word;
   assign status_word = {captured.was_read, 28'h0000000, captured.channel}; // [R04]

   ////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data taken in either order, held until paired

   logic        aw_held;
   logic [7:0]  aw_addr;
   logic        w_held;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        irq_stat;
   logic        irq_mask;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;

   wire logic aw_fire = s_axi_awvalid && s_axi_awready;
   wire logic w_fire  = s_axi_wvalid && s_axi_wready;

   wire logic       have_aw  = aw_held || aw_fire;
   wire logic       have_w   = w_held || w_fire;
   wire logic       do_write = have_aw && have_w;
   wire logic [7:0] wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
   wire logic [31:0] wr_data = w_held ? w_data : s_axi_wdata;
   wire logic [3:0] wr_strb  = w_held ? w_strb : s_axi_wstrb;

   // Capture registers accept the write but keep their contents
   wire logic wr_known = (wr_addr == `DEC_ADDR_STATUS) || (wr_addr == `DEC_ADDR_ADDRESS) ||
                         (wr_addr == `DEC_ADDR_IRQ_STAT) || (wr_addr == `DEC_ADDR_IRQ_MASK);
   wire logic wr_clr   = do_write && (wr_addr == `DEC_ADDR_IRQ_STAT) && wr_strb[0] &&
                         wr_data[`DEC_IRQ_ERR_BIT];
   wire logic wr_mask  = do_write && (wr_addr == `DEC_ADDR_IRQ_MASK) && wr_strb[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end else if (aw_fire) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else if (do_write) begin
         w_held <= 1'b0;
      end else if (w_fire) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `DEC_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_known ? `DEC_RESP_OKAY : `DEC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt: sticky error flag, set wins over a write-one clear

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat <= `DEC_IRQ_RESET;
      end else if (err_strobe) begin
         irq_stat <= 1'b1;
      end else if (wr_clr) begin
         irq_stat <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask <= `DEC_IRQ_RESET;
      end else if (wr_mask) begin
         irq_mask <= wr_data[`DEC_IRQ_ERR_BIT];
      end
   end

   assign irq = irq_stat && irq_mask;

   ////////////////////////////////////////////////////////////////////////////
   // Read channel: one cycle to data

   assign s_axi_arready = !s_axi_rvalid;

   wire logic ar_fire = s_axi_arvalid && s_axi_arready;

   wire logic rd_status  = (s_axi_araddr == `DEC_ADDR_STATUS);
   wire logic rd_address = (s_axi_araddr == `DEC_ADDR_ADDRESS);
   wire logic rd_istat   = (s_axi_araddr == `DEC_ADDR_IRQ_STAT);
   wire logic rd_imask   = (s_axi_araddr == `DEC_ADDR_IRQ_MASK);
   wire logic rd_known   = rd_status || rd_address || rd_istat || rd_imask;

   wire logic [31:0] rd_value;
   assign rd_value = rd_status  ? status_word :
                     rd_address ? captured.address :
                     rd_istat   ? {31'h00000000, irq_stat} :
                     rd_imask   ? {31'h00000000, irq_mask} :
                     32'h00000000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `DEC_RESP_OKAY;
      end else if (ar_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_value;
         s_axi_rresp  <= rd_known ? `DEC_RESP_OKAY : `DEC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : dec_error_capture

// file: dec_error_capture_props.sv
`timescale 1ns/1ps
module dec_error_capture_props (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Error report
   input wire logic        err_strobe,
   input wire logic        err_was_read,
   input wire logic [2:0]  err_channel,
   input wire logic [31:0] err_address,
   // Read channels
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Shadow of the last error; writes never touch it, so it also proves read-only
   logic        sh_rd;
   logic [2:0]  sh_ch;
   logic [31:0] sh_ad;
   always_ff @(posedge aclk) begin
      if (!aresetn)
         {sh_rd, sh_ch, sh_ad} <= '0;
      else if (err_strobe)
         {sh_rd, sh_ch, sh_ad} <= {err_was_read, err_channel, err_address};
   end
   ////////////////////////////////////////
   sequence s_rd(logic [7:0] a);
      s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
   endsequence
   AST_DIR: assert property (s_rd(8'h00) |=> s_axi_rvalid && s_axi_rdata[31] == $past(sh_rd))
      else $error("direction bit wrong");
   AST_CH: assert property (s_rd(8'h00) |=> s_axi_rdata[2:0] == $past(sh_ch))
      else $error("channel field wrong");
   AST_ADDR: assert property (s_rd(8'h04) |=> s_axi_rvalid && s_axi_rdata == $past(sh_ad))
      else $error("error address wrong");
   AST_ZERO: assert property (s_rd(8'h00) |=> s_axi_rdata[30:3] == 28'h0000000)
      else $error("middle status bits not zero");
   AST_FULL: assert property (s_rd(8'h00) |=> s_axi_rdata == {$past(sh_rd), 28'h0000000, $past(sh_ch)})
      else $error("status word wrong");
endmodule : dec_error_capture_props
bind dec_error_capture dec_error_capture_props dec_error_capture_props_i (.aclk(aclk), .aresetn(aresetn),
   .err_strobe(err_strobe), .err_was_read(err_was_read), .err_channel(err_channel), .err_address(err_address),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata));

// file: dec_error_capture_bench.sv
`timescale 1ns/1ps
`include "dec_params.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module dec_error_capture_bench;
   import dec_pkg::*;
   logic        aclk = 0, aresetn = 0, err_strobe = 0, err_was_read = 0, irq;
   logic [2:0]  err_channel = 0, s_axi_awprot = 0, s_axi_arprot = 0;
   logic [31:0] err_address = 0, s_axi_wdata = 0, s_axi_rdata;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_bready = 1, s_axi_rready = 1;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [3:0]  s_axi_wstrb = 4'hF;
   int          bad_count = 0, total_checks = 0, cyc = 0;
   dec_error_capture dec_error_capture_i (.*);
   always #4 aclk = ~aclk;
   ////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // Whole run is well under two hundred cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         summarize;
      end
   end
   // Strobe stays high so back-to-back errors need no gap
   task automatic err(input logic r, input logic [2:0] c, input logic [31:0] a);
      err_strobe   <= 1'h1;
      err_was_read <= r;
      err_channel  <= c;
      err_address  <= a;
      @(posedge aclk);
   endtask : err
   task automatic quiet;
      err_strobe <= 1'h0;
      @(posedge aclk);
   endtask : quiet
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `DEC_RESP_OKAY);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      `CHK(s_axi_bresp, r)
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `DEC_RESP_OKAY);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      `CHK(s_axi_rdata, d)
      `CHK(s_axi_rresp, r)
   endtask : rd
   ////////////////////////////////////////
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rd(`DEC_ADDR_STATUS, 32'h0000_0000);
      rd(`DEC_ADDR_ADDRESS, 32'h0000_0000);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         err(i[0], i[2:0], 32'hFFFF_FFFF >> (4 * i));
         quiet;
         rd(`DEC_ADDR_STATUS, {i[0], 28'h000_0000, i[2:0]});
         rd(`DEC_ADDR_ADDRESS, 32'hFFFF_FFFF >> (4 * i));
      end
      err(1'h1, 3'h6, 32'hA5A5_0000);
      err(1'h0, 3'h2, 32'h0000_5A5C);
      quiet;
      rd(`DEC_ADDR_STATUS, 32'h0000_0002);
      rd(`DEC_ADDR_ADDRESS, 32'h0000_5A5C);
      $display("capture test done");
      wr(`DEC_ADDR_STATUS, 32'hFFFF_FFFF);
      wr(`DEC_ADDR_ADDRESS, 32'h0000_0000);
      rd(`DEC_ADDR_STATUS, 32'h0000_0002);
      rd(`DEC_ADDR_ADDRESS, 32'h0000_5A5C);
      rd(8'h10, 32'h0000_0000, `DEC_RESP_SLVERR);
      wr(8'h10, 32'h0000_0001, `DEC_RESP_SLVERR);
      $display("read-only test done");
      wr(`DEC_ADDR_IRQ_MASK, 32'h0000_0001);
      `CHK(irq, 1'h1)
      wr(`DEC_ADDR_IRQ_STAT, 32'h0000_0001);
      `CHK(irq, 1'h0)
      rd(`DEC_ADDR_IRQ_STAT, 32'h0000_0000);
      wr(`DEC_ADDR_IRQ_MASK, 32'h0000_0000);
      err(1'h1, 3'h5, 32'h0000_0004);
      quiet;
      `CHK(irq, 1'h0)
      rd(`DEC_ADDR_IRQ_STAT, 32'h0000_0001);
      rd(`DEC_ADDR_STATUS, 32'h8000_0005);
      $display("interrupt test done");
      summarize;
   end
endmodule : dec_error_capture_bench
